// ===== rtl/host_slave_port.sv
// Device end of the parallel host port, with an APB register file for firmware.
// Assumes the host gates its strobes and holds data stable while strobing.
`timescale 1ns/1ns
`default_nettype none
module host_slave_port (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt to firmware.
  output logic irq,
  // Host pins.
  host_slave_port_if.device port
);
  logic [3:0] ctrl;
  logic [15:0] gpio;
  logic [15:0] input_buffer;
  logic [15:0] output_buffer;
  logic [15:0] drive_data;
  logic cmd_select;
  logic read_select;
  logic write_ready_flag;
  logic out_full;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic wr_meta;
  logic wr_sync;
  logic wr_prev;
  logic rd_meta;
  logic rd_sync;
  logic rd_prev;

  wire wide = ctrl[host_port_pkg::CTRL_WIDE_BIT];
  wire handshake = ctrl[host_port_pkg::CTRL_HANDSHAKE_BIT];
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire apb_rd = apb_access & ~pwrite;
  wire sel_ctrl = paddr == host_port_pkg::CTRL_OFFSET;
  wire sel_inbuf = paddr == host_port_pkg::INBUF_OFFSET;
  wire sel_outbuf = paddr == host_port_pkg::OUTBUF_OFFSET;
  wire sel_stat = paddr == host_port_pkg::PORT_STATUS_OFFSET;
  wire sel_irq_stat = paddr == host_port_pkg::IRQ_STATUS_OFFSET;
  wire sel_irq_clr = paddr == host_port_pkg::IRQ_CLEAR_OFFSET;
  wire sel_irq_en = paddr == host_port_pkg::IRQ_ENABLE_OFFSET;
  wire sel_gpio = paddr == host_port_pkg::GPIO_OFFSET;
  wire mapped = sel_ctrl | sel_inbuf | sel_outbuf | sel_stat |
    sel_irq_stat | sel_irq_clr | sel_irq_en | sel_gpio;
  // Synchronised strobe edges drive all host-side flag updates.
  wire write_done = wr_sync & ~wr_prev;
  wire read_done = rd_sync & ~rd_prev;
  wire fetch_done = read_done & read_select;
  wire inbuf_taken = apb_rd & sel_inbuf;
  wire outbuf_load = apb_wr & sel_outbuf;
  wire [1:0] irq_events = {fetch_done, write_done};
  wire [15:0] status_word = {13'h0000, cmd_select, out_full, write_ready_flag};
  wire [15:0] width_mask = wide ? 16'hffff : 16'h00ff;
  wire [15:0] rd_drive_n = {16{port.host_read_strobe_n}} | ~width_mask;
  wire [15:0] gpio_drive_n = width_mask | ~{gpio[15:8], 8'h00};

  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign irq = |(irq_status & irq_enable);
  // Upper pins become general purpose outputs in narrow mode.
  assign port.dev_data_oe_n = rd_drive_n & gpio_drive_n;
  assign port.dev_data_out = wide ? drive_data :
    {gpio[7:0], drive_data[7:0]};
  // Ready pins fall back to firmware-driven levels when unused.
  assign port.write_ready = handshake ? write_ready_flag :
    ctrl[host_port_pkg::CTRL_WR_PIN_BIT];
  assign port.read_ready_n = handshake ? ~out_full :
    ctrl[host_port_pkg::CTRL_RD_PIN_BIT];

  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      prdata = {28'h000_0000, ctrl};
    end else if (sel_inbuf) begin
      prdata = {16'h0000, input_buffer & width_mask};
    end else if (sel_outbuf) begin
      prdata = {16'h0000, output_buffer};
    end else if (sel_stat) begin
      prdata = {8'h00, port.data[15:8], status_word};
    end else if (sel_irq_stat) begin
      prdata = {30'h0000_0000, irq_status};
    end else if (sel_irq_en) begin
      prdata = {30'h0000_0000, irq_enable};
    end else if (sel_gpio) begin
      prdata = {16'h0000, gpio};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_meta <= 1'b1;
      wr_sync <= 1'b1;
      wr_prev <= 1'b1;
      rd_meta <= 1'b1;
      rd_sync <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      // Two flip-flop synchronisers, then an edge stage.
      wr_meta <= port.host_write_strobe_n;
      wr_sync <= wr_meta;
      wr_prev <= wr_sync;
      rd_meta <= port.host_read_strobe_n;
      rd_sync <= rd_meta;
      rd_prev <= rd_sync;
    end
  end

  // The buffer follows the pins while the strobe is low, as a fall-through.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_buffer <= 16'h0000;
      cmd_select <= 1'b0;
    end else if (!port.host_write_strobe_n) begin
      input_buffer <= port.data;
      cmd_select <= port.host_addr_select;
    end
  end

  // The read path latches the address select and prepares the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_select <= 1'b0;
      drive_data <= 16'h0000;
    end else if (!port.host_read_strobe_n) begin
      read_select <= port.host_addr_select;
      // Select one returns data, zero returns the status word.
      drive_data <= port.host_addr_select ? output_buffer :
        status_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_ready_flag <= 1'b0;
    end else if (write_done) begin
      write_ready_flag <= 1'b1;
    end else if (inbuf_taken) begin
      write_ready_flag <= 1'b0;
    end
  end

  // A status poll has read_select low and so never clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_full <= 1'b0;
      output_buffer <= 16'h0000;
    end else if (outbuf_load) begin
      out_full <= 1'b1;
      output_buffer <= pwdata[15:0] & width_mask;
    end else if (fetch_done) begin
      out_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= host_port_pkg::CTRL_RESET;
      gpio <= 16'h0000;
      irq_enable <= 2'b00;
    end else if (apb_wr) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[3:0];
      end
      if (sel_gpio) begin
        gpio <= pwdata[15:0];
      end
      if (sel_irq_en) begin
        irq_enable <= pwdata[1:0];
      end
    end
  end

  // New events win over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'b00;
    end else if (apb_wr && sel_irq_clr) begin
      irq_status <= (irq_status & ~pwdata[1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end
endmodule
`default_nettype wire

// ===== include/host_port_pkg.sv
// Constants shared by the host slave port ends: register map, fields, timing.
// Assumes a 250 MHz pclk and 32-bit APB on the firmware side.
package host_port_pkg;
  localparam int PORT_WIDTH = 16;
  localparam int NARROW_WIDTH = 8;
  localparam int CLK_PERIOD_NS = 4;
  // Firmware register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] INBUF_OFFSET = 8'h04;
  localparam logic [7:0] OUTBUF_OFFSET = 8'h08;
  localparam logic [7:0] PORT_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h14;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h18;
  localparam logic [7:0] GPIO_OFFSET = 8'h1c;
  // Control register fields.
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_HANDSHAKE_BIT = 1;
  localparam int CTRL_WR_PIN_BIT = 2;
  localparam int CTRL_RD_PIN_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;
  // Status word fields, both for the host poll and firmware.
  localparam int STAT_WRITE_READY_BIT = 0;
  localparam int STAT_READ_READY_BIT = 1;
  localparam int STAT_ADDR_SEL_BIT = 2;
  // Interrupt status fields.
  localparam int IRQ_WRITE_BIT = 0;
  localparam int IRQ_READ_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  // Host strobe timing.
  localparam int STROBE_NS = 16;
  localparam int RECOVER_NS = 24;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== include/host_slave_port_if.sv
// Pin bundle between the external host and the device's parallel port.
// Assumes each driver reports its own enables; the wire level is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface host_slave_port_if;
  logic [15:0] host_data_out;
  logic [15:0] host_data_oe_n;
  logic [15:0] dev_data_out;
  logic [15:0] dev_data_oe_n;
  wire [15:0] data;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic host_addr_select;
  logic read_ready_n;
  logic write_ready;

  // Undriven bits float high as through a pull-up.
  assign data = (~dev_data_oe_n & dev_data_out) |
    (dev_data_oe_n & ~host_data_oe_n & host_data_out) |
    (dev_data_oe_n & host_data_oe_n);

  modport device (
    input data, host_read_strobe_n, host_write_strobe_n, host_addr_select,
    output dev_data_out, dev_data_oe_n, read_ready_n, write_ready
  );
  modport host (
    input data, read_ready_n, write_ready,
    output host_data_out, host_data_oe_n, host_read_strobe_n,
    output host_write_strobe_n, host_addr_select
  );
endinterface
`default_nettype wire

// ===== rtl/host_port_master.sv
// Host end of the parallel port: strobe generation, wait states, interrupts.
// Assumes the host bus is synchronous to pclk and the decode selects this port.
`timescale 1ns/1ns
`default_nettype none
module host_port_master (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Host bus request.
  input wire logic req,
  input wire logic req_write,
  input wire logic req_addr_select,
  input wire logic [15:0] req_wdata,
  input wire logic wide,
  input wire logic hw_sync,
  output logic ack,
  output logic [15:0] rdata,
  output logic busy_wait,
  // Host interrupt.
  input wire logic [1:0] host_irq_enable,
  input wire logic [1:0] host_irq_clear,
  output logic host_irq,
  // Device pins.
  host_slave_port_if.host port
);
  typedef enum {IDLE, WAIT_READY, STROBE, RECOVER} host_state_t;
  host_state_t state;
  host_state_t next_state;
  logic [7:0] count;
  logic is_write;
  logic sel;
  logic [15:0] wdata;
  logic wr_ready_prev;
  logic rd_ready_n_prev;
  logic [1:0] irq_flags;

  wire data_access = sel;
  // Status accesses never stall.
  wire not_ready = data_access & (is_write ? port.write_ready :
    port.read_ready_n);
  wire stall = hw_sync & not_ready;
  wire strobe_end = count == 8'(host_port_pkg::STROBE_CYCLES - 1);
  wire recover_end = count == 8'(host_port_pkg::RECOVER_CYCLES - 1);
  wire [15:0] mask = wide ? 16'hffff : 16'h00ff;
  // Falling ready edges mean the device became ready.
  wire [1:0] irq_events = {rd_ready_n_prev & ~port.read_ready_n,
    wr_ready_prev & ~port.write_ready};
  wire in_strobe = state == STROBE;

  // Strobes exist only inside a selected access.
  assign port.host_write_strobe_n = ~(in_strobe & is_write);
  assign port.host_read_strobe_n = ~(in_strobe & ~is_write);
  assign port.host_addr_select = sel;
  assign port.host_data_out = wdata;
  assign port.host_data_oe_n = ~({16{is_write & state != IDLE}} & mask);
  assign ack = state == RECOVER && recover_end;
  assign busy_wait = state == WAIT_READY;
  assign host_irq = |(irq_flags & host_irq_enable);

  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (req) begin
          next_state = WAIT_READY;
        end
      end
      WAIT_READY: begin
        if (!stall) begin
          next_state = STROBE;
        end
      end
      STROBE: begin
        if (strobe_end) begin
          next_state = RECOVER;
        end
      end
      RECOVER: begin
        if (recover_end) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? 8'h00 : count + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_write <= 1'b0;
      sel <= 1'b0;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
    end else if (state == IDLE && req) begin
      is_write <= req_write;
      sel <= req_addr_select;
      wdata <= req_wdata & mask;
    end else if (in_strobe && strobe_end && !is_write) begin
      rdata <= port.data & mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ready_prev <= 1'b0;
      rd_ready_n_prev <= 1'b1;
      irq_flags <= 2'b00;
    end else begin
      wr_ready_prev <= port.write_ready;
      rd_ready_n_prev <= port.read_ready_n;
      irq_flags <= (irq_flags & ~host_irq_clear) | irq_events;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/unused_placeholder_none.sv
// Intentionally empty design unit list.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/host_slave_port_monitor.sv
// Checker on the pins between the host end and the device end.
// Assumes the ready handshake stays on and the host runs with wait states.
`timescale 1ns/1ns
`default_nettype none
module host_slave_port_monitor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Port pins.
  input wire logic [15:0] data,
  input wire logic [15:0] dev_data_oe_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_addr_select,
  input wire logic read_ready_n,
  input wire logic write_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RESET_REST: assert property (
    $rose(presetn) |-> !write_ready && read_ready_n)
    else $error("ready pins not at rest after reset");
  AST_WRITE_READY_RISE: assert property (
    $rose(host_write_strobe_n) |-> ##[1:4] write_ready)
    else $error("write ready did not rise after a host write");
  AST_FETCH_CLEARS: assert property (
    $rose(host_read_strobe_n) && $past(host_addr_select)
    |-> ##[1:4] read_ready_n)
    else $error("read ready not cleared after a data fetch");
  AST_STATUS_KEEPS: assert property (
    $rose(host_read_strobe_n) && !$past(host_addr_select) && !read_ready_n
    |-> ##1 !read_ready_n [*4])
    else $error("status poll changed read ready");
  AST_STATUS_WORD: assert property (
    !host_read_strobe_n && !$past(host_read_strobe_n) && !host_addr_select
    |-> data[1:0] == {!read_ready_n, write_ready})
    else $error("status word bits wrong");
  AST_FETCH_DRIVES: assert property (
    !host_read_strobe_n && !$past(host_read_strobe_n)
    |-> dev_data_oe_n[7:0] == 8'h00)
    else $error("device not driving data during a read");
  AST_IDLE_RELEASE: assert property (
    host_read_strobe_n && $past(host_read_strobe_n)
    |-> dev_data_oe_n[7:0] == 8'hff)
    else $error("device drives data outside a read");
  AST_WRITE_WHEN_FREE: assert property (
    $fell(host_write_strobe_n) |-> !write_ready)
    else $error("host wrote into a full input buffer");
  AST_READ_WHEN_READY: assert property (
    $fell(host_read_strobe_n) ##1 host_addr_select |-> !read_ready_n)
    else $error("host fetched with no data waiting");
  AST_ONE_STROBE: assert property (
    host_read_strobe_n || host_write_strobe_n)
    else $error("both strobes low at once");
endmodule
`default_nettype wire

// ===== tb/host_slave_port_tb_top.sv
// Bench joining the host end and the device end of the parallel port.
// Assumes zero-wait APB and the host strobe timing of the shared package.
`timescale 1ns/1ns
`default_nettype none
module host_slave_port_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_addr_select = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic wide = 1'b1;
  logic hw_sync = 1'b1;
  logic ack;
  logic busy_wait;
  logic host_irq;
  logic [15:0] rdata;
  logic [1:0] host_irq_enable = 2'b01;
  logic [1:0] host_irq_clear = 2'b00;
  integer miscompares = 0;
  integer n_checks = 0;
  integer seed = 32'h8fa9;
  int host_cycles;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] e;
  logic [15:0] mask;
  logic err;
  logic w;
  host_slave_port_if port_if ();
  always #(host_port_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
  host_slave_port host_slave_port_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .port(port_if));
  host_port_master host_port_master_inst (.pclk(pclk), .presetn(presetn),
    .req(req), .req_write(req_write), .req_addr_select(req_addr_select),
    .req_wdata(req_wdata), .wide(wide), .hw_sync(hw_sync), .ack(ack),
    .rdata(rdata), .busy_wait(busy_wait), .host_irq_enable(host_irq_enable),
    .host_irq_clear(host_irq_clear), .host_irq(host_irq), .port(port_if));
  host_slave_port_monitor host_slave_port_monitor_inst (.pclk(pclk),
    .presetn(presetn), .data(port_if.data),
    .dev_data_oe_n(port_if.dev_data_oe_n),
    .host_read_strobe_n(port_if.host_read_strobe_n),
    .host_write_strobe_n(port_if.host_write_strobe_n),
    .host_addr_select(port_if.host_addr_select),
    .read_ready_n(port_if.read_ready_n), .write_ready(port_if.write_ready));
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("apb wait", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic host(input logic wr, input logic sel, input logic [15:0] wd);
    int n;
    req <= 1'b1;
    req_write <= wr;
    req_addr_select <= sel;
    req_wdata <= wd;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ack !== 1'b1 && n < 300);
    if (n >= 300) begin
      check("host wait", 32'h1, 32'h0);
      print_verdict();
    end
    host_cycles = n;
    req <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [7:0] upper_pins(input logic [15:0] g);
    // Enabled upper pins show their output bit, the others float high.
    return g[7:0] | ~g[15:8];
  endfunction
  task automatic do_reset();
    wide <= 1'b1;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    check("write_ready", 32'(port_if.write_ready), 32'h0);
    check("read_ready_n", 32'(port_if.read_ready_n), 32'h1);
    apb(1'b0, host_port_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl", rd, 32'h0000_0003);
    host(1'b0, 1'b0, 16'h0000);
    check("status", 32'(rdata[1:0]), 32'h0);
    check("status wait", 32'(host_cycles <= 13), 32'h1);
  endtask
  initial begin
    do_reset();
    apb(1'b1, host_port_pkg::IRQ_ENABLE_OFFSET, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      w = (i % 2 == 0);
      wide <= w;
      mask = w ? 16'hffff : 16'h00ff;
      apb(1'b1, host_port_pkg::CTRL_OFFSET, 32'h0000_0002 | 32'(w));
      d = $random(seed);
      host(1'b1, d[16], d[15:0]);
      repeat (4) @(posedge pclk);
      check("write_ready", 32'(port_if.write_ready), 32'h1);
      apb(1'b0, host_port_pkg::PORT_STATUS_OFFSET, 32'h0);
      check("addr sel", 32'(rd[2]), 32'(d[16]));
      apb(1'b0, host_port_pkg::IRQ_STATUS_OFFSET, 32'h0);
      check("write event", 32'(rd[0]), 32'h1);
      check("irq", 32'(irq), 32'h1);
      apb(1'b0, host_port_pkg::INBUF_OFFSET, 32'h0);
      check("inbuf", rd & 32'(mask), d & 32'(mask));
      check("write_ready", 32'(port_if.write_ready), 32'h0);
      repeat (2) @(posedge pclk);
      check("host_irq", 32'(host_irq), 32'h1);
      host_irq_clear <= 2'b11;
      @(posedge pclk);
      host_irq_clear <= 2'b00;
      apb(1'b1, host_port_pkg::IRQ_CLEAR_OFFSET, 32'h0000_0003);
      check("irq", 32'(irq), 32'h0);
      e = $random(seed);
      apb(1'b1, host_port_pkg::OUTBUF_OFFSET, e);
      repeat (2) @(posedge pclk);
      check("read_ready_n", 32'(port_if.read_ready_n), 32'h0);
      host_irq_enable <= 2'b10;
      @(posedge pclk);
      check("host_irq read", 32'(host_irq), 32'h1);
      host_irq_enable <= 2'b01;
      host(1'b0, 1'b0, 16'h0000);
      check("status", 32'(rdata[1:0]), 32'h2);
      check("read_ready_n", 32'(port_if.read_ready_n), 32'h0);
      host(1'b0, 1'b1, 16'h0000);
      check("fetch", 32'(rdata & mask), e & 32'(mask));
      check("read_ready_n", 32'(port_if.read_ready_n), 32'h1);
      apb(1'b0, host_port_pkg::IRQ_STATUS_OFFSET, 32'h0);
      check("fetch event", 32'(rd[1]), 32'h1);
      check("irq masked", 32'(irq), 32'h0);
      apb(1'b1, host_port_pkg::IRQ_CLEAR_OFFSET, 32'h0000_0003);
    end
    d = $random(seed);
    e = $random(seed);
    host(1'b1, 1'b1, d[15:0]);
    fork
      host(1'b1, 1'b1, e[15:0]);
      begin
        repeat (30) @(posedge pclk);
        check("busy_wait", 32'(busy_wait), 32'h1);
        apb(1'b0, host_port_pkg::INBUF_OFFSET, 32'h0);
        check("first", rd & 32'(mask), d & 32'(mask));
      end
    join
    repeat (4) @(posedge pclk);
    apb(1'b0, host_port_pkg::INBUF_OFFSET, 32'h0);
    check("second", rd & 32'(mask), e & 32'(mask));
    fork
      host(1'b0, 1'b1, 16'h0000);
      begin
        repeat (30) @(posedge pclk);
        check("busy_wait", 32'(busy_wait), 32'h1);
        apb(1'b1, host_port_pkg::OUTBUF_OFFSET, d);
      end
    join
    check("late fetch", 32'(rdata & mask), d & 32'(mask));
    apb(1'b0, 8'h40, 32'h0);
    check("pslverr", 32'(err), 32'h1);
    check("unmapped", rd, 32'h0);
    // Ready pins as plain outputs, upper pins as general purpose I/O.
    e = $random(seed);
    apb(1'b1, host_port_pkg::CTRL_OFFSET, {28'h000_0000, e[3:2], 2'b00});
    d = 32'({port_if.read_ready_n, port_if.write_ready});
    check("ready pins", d, 32'(e[3:2]));
    apb(1'b1, host_port_pkg::GPIO_OFFSET, e);
    d = 32'(upper_pins(e[15:0]));
    check("gpio pins", 32'(port_if.data[15:8]), d);
    apb(1'b0, host_port_pkg::PORT_STATUS_OFFSET, 32'h0);
    check("gpio status", 32'(rd[23:16]), d);
    do_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
